/* File: design/sram_input_pkg.sv */
// ----------------------------------------------------------------------------
// Shared constants and types for the synchronous SRAM input qualifier.
// ----------------------------------------------------------------------------
package sram_input_pkg;

  // Width of the internal burst counter and of the seed taken from the
  // low address bits.
  localparam int BURST_W = 2;

  // Position of the lowest seed bit within the external address.
  localparam int SEED_LSB = 0;

  // Number of byte lanes in one word.
  localparam int BYTE_LANES = 4;

  // Documented default width of the external word address.
  localparam int ADDR_W_DEF = 18;

  // Default for the third chip select: 1 means the pin is present.
  localparam bit HAS_THIRD_CS_DEF = 1'b1;

  // Reset value of the burst counter.
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;

  // Burst counter step on an advance edge.
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;

  // Byte write mask for no bytes and for every byte.
  localparam logic [BYTE_LANES-1:0] LANES_NONE = 4'h0;
  localparam logic [BYTE_LANES-1:0] LANES_ALL  = 4'hf;

  // Selection state, one-hot.
  typedef enum logic [1:0] {
    ST_DESELECTED = 2'h1,
    ST_SELECTED   = 2'h2
  } sel_state_t;

  // Per-cycle access decision, carried as one registered bundle.
  typedef struct packed {
    logic                  load;     // A new external address was taken.
    logic                  read;     // The access is a read.
    logic [BYTE_LANES-1:0] byte_we;  // Byte lanes to be written.
  } access_t;

endpackage : sram_input_pkg

/* File: design/sram_input_ctrl.sv */
// Notes on behaviour
// - Capture address only when strobed and selected.
// - Load low address bits into burst counter.
// - Byte lane selects choose written bytes.
// - Global write writes all bytes.
// - Byte write needs qualifier sampled low.
// - Advance input low steps the burst counter.
// - Primary chip select is active low.
// - Processor strobe ignored while primary select high.
// - Secondary chip select is active high.
// - Chip selects sampled only on address loads.
// - Third select active low, absent means active.
// - Both strobes low: processor strobe wins.
`timescale 1ns/1ps

module sram_input_ctrl #(
  parameter int ADDR_W       = sram_input_pkg::ADDR_W_DEF,
  parameter bit HAS_THIRD_CS = sram_input_pkg::HAS_THIRD_CS_DEF
) (
  // Clock and reset.
  input  wire logic                                  CLK_IN,
  input  wire logic                                  SYS_RST_IN,
  // Address and strobes.
  input  wire logic [ADDR_W-1:0]                     ADDRESS_IN,
  input  wire logic                        PROCESSOR_ADDRESS_STROBE_N_IN,
  input  wire logic                        CONTROLLER_ADDRESS_STROBE_N_IN,
  input  wire logic                                  BURST_ADVANCE_N_IN,
  // Chip selects.
  input  wire logic                                  PRIMARY_CHIP_SELECT_N_IN,
  input  wire logic                                  SECONDARY_CHIP_SELECT_IN,
  input  wire logic                                  THIRD_CHIP_SELECT_N_IN,
  // Write controls.
  input  wire logic                                  GLOBAL_WRITE_N_IN,
  input  wire logic                                  BYTE_WRITE_QUALIFIER_N_IN,
  input  wire logic [sram_input_pkg::BYTE_LANES-1:0] BYTE_LANE_WRITE_SELECT_N_IN,
  // Captured address and burst position.
  output logic      [ADDR_W-1:0]                     ADDRESS_OUT,
  output logic      [sram_input_pkg::BURST_W-1:0]    BURST_SEED_BITS_OUT,
  // Access decision.
  output logic                                       SELECTED_OUT,
  output logic                                       ADDRESS_LOAD_OUT,
  output logic                                       READ_OUT,
  output logic      [sram_input_pkg::BYTE_LANES-1:0] BYTE_WRITE_OUT
);

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------

  // The seed bits must exist within the address.
  if (ADDR_W < sram_input_pkg::BURST_W + sram_input_pkg::SEED_LSB) begin
    $error("ADDR_W too small to hold the burst seed bits");
  end

  // --------------------------------------------------------------------------
  // Input qualification
  // --------------------------------------------------------------------------

  logic proc_take;    // Processor strobe accepted this edge.
  logic ctrl_take;    // Controller strobe accepted this edge.
  logic load_now;     // An address strobe is accepted this edge, selected or not.
  logic third_ok;     // Third chip select seen as active.
  logic sel_now;      // All chip selects active this edge.
  logic active_now;   // The device takes part in this edge's access.

  // The selection state is declared here because the decode below reads it.
  sram_input_pkg::sel_state_t sel_q;  // Selection decision in force.
  sram_input_pkg::sel_state_t sel_d;  // Next selection decision.

  // Strobes and selects are decoded combinationally from the sampled pins.
  always_comb begin
    // A processor strobe is void while the primary select is high.
    proc_take = !PROCESSOR_ADDRESS_STROBE_N_IN
                && !PRIMARY_CHIP_SELECT_N_IN;
    // The controller strobe only counts when the processor strobe is not
    // low; when both are low the processor strobe decides alone.
    ctrl_take = !CONTROLLER_ADDRESS_STROBE_N_IN
                && PROCESSOR_ADDRESS_STROBE_N_IN;
    load_now  = proc_take || ctrl_take;
    // Without the third pin the select is treated as always active.
    third_ok  = HAS_THIRD_CS ? !THIRD_CHIP_SELECT_N_IN : 1'b1;
    // Every enable must be in its active state to select.
    sel_now   = !PRIMARY_CHIP_SELECT_N_IN
                && SECONDARY_CHIP_SELECT_IN
                && third_ok;
    // Burst cycles keep the decision made at the last load.
    active_now = load_now ? sel_now
                          : (sel_q == sram_input_pkg::ST_SELECTED);
  end

  // --------------------------------------------------------------------------
  // Selection state
  // --------------------------------------------------------------------------

  // The chip selects are looked at only on an address load; this is what
  // lets a burst run on while the selects move for another bank.
  always_comb begin
    sel_d = sel_q;
    unique case (sel_q)
      sram_input_pkg::ST_DESELECTED: begin
        // Stay deselected until a load with every select active.
        if (load_now && sel_now) begin
          sel_d = sram_input_pkg::ST_SELECTED;
        end
      end
      sram_input_pkg::ST_SELECTED: begin
        // A load with any select inactive deselects the device.
        if (load_now && !sel_now) begin
          sel_d = sram_input_pkg::ST_DESELECTED;
        end
      end
      default: begin
        // An illegal code recovers to the safe, deselected state.
        sel_d = sram_input_pkg::ST_DESELECTED;
      end
    endcase
  end

  // Registers the selection state.
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      sel_q <= sram_input_pkg::ST_DESELECTED;
    end else begin
      sel_q <= sel_d;
    end
  end

  // --------------------------------------------------------------------------
  // Address register and burst counter
  // --------------------------------------------------------------------------

  logic [ADDR_W-1:0]                  addr_q;   // Captured address.
  logic [ADDR_W-1:0]                  addr_d;   // Next captured address.
  logic [sram_input_pkg::BURST_W-1:0] burst_q;  // Burst counter.
  logic [sram_input_pkg::BURST_W-1:0] burst_d;  // Next burst count.

  // A load that deselects keeps the old address; the counter simply wraps
  // in its two bits, so the sequence order beyond it lives elsewhere.
  always_comb begin
    addr_d  = addr_q;
    burst_d = burst_q;
    if (load_now) begin
      if (sel_now) begin
        // Capture the new address and seed the counter from it.
        addr_d  = ADDRESS_IN;
        burst_d = ADDRESS_IN[sram_input_pkg::SEED_LSB
                             +: sram_input_pkg::BURST_W];
      end
    end else if (active_now && !BURST_ADVANCE_N_IN) begin
      // Step the burst counter on an advance edge of a live burst.
      burst_d = burst_q + sram_input_pkg::BURST_STEP;
    end
  end

  // Registers the address and counter.
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      addr_q  <= '0;
      burst_q <= sram_input_pkg::BURST_RST;
    end else begin
      addr_q  <= addr_d;
      burst_q <= burst_d;
    end
  end

  // --------------------------------------------------------------------------
  // Write decision
  // --------------------------------------------------------------------------

  sram_input_pkg::access_t acc_q;  // Registered access decision.
  sram_input_pkg::access_t acc_d;  // Next access decision.

  // Global write overrides the lane selects; otherwise the qualifier must
  // be low for the lanes to count. An idle edge writes nothing.
  always_comb begin
    acc_d.load    = load_now && sel_now;
    acc_d.read    = 1'b0;
    acc_d.byte_we = sram_input_pkg::LANES_NONE;
    if (active_now) begin
      if (!GLOBAL_WRITE_N_IN) begin
        // Every byte, regardless of lanes and qualifier.
        acc_d.byte_we = sram_input_pkg::LANES_ALL;
      end else if (!BYTE_WRITE_QUALIFIER_N_IN) begin
        // Only the lanes whose select is low.
        acc_d.byte_we = ~BYTE_LANE_WRITE_SELECT_N_IN;
      end else begin
        // Neither write control is low: the access reads.
        acc_d.read = 1'b1;
      end
    end
  end

  // Registers the access decision.
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------

  // Every output but SELECTED_OUT is a flip-flop output; SELECTED_OUT decodes sel_q.
  always_comb begin
    ADDRESS_OUT         = addr_q;
    BURST_SEED_BITS_OUT = burst_q;
    SELECTED_OUT        = (sel_q == sram_input_pkg::ST_SELECTED);
    ADDRESS_LOAD_OUT    = acc_q.load;
    READ_OUT            = acc_q.read;
    BYTE_WRITE_OUT      = acc_q.byte_we;
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);

  // A selected load captures the pins.
  a_addr_capture: assert property (
    load_now && sel_now |=> ADDRESS_OUT == $past(ADDRESS_IN))
    else $error("address not captured on a selected load");

  // A selected load seeds the counter from the low address bits.
  a_burst_seed: assert property (
    load_now && sel_now |=> BURST_SEED_BITS_OUT
      == $past(ADDRESS_IN[sram_input_pkg::SEED_LSB
                          +: sram_input_pkg::BURST_W]))
    else $error("burst counter not seeded from the address");

  // Lane selects drive the write mask under the qualifier.
  a_lane_mask: assert property (
    active_now && GLOBAL_WRITE_N_IN && !BYTE_WRITE_QUALIFIER_N_IN
    |=> BYTE_WRITE_OUT == ~$past(BYTE_LANE_WRITE_SELECT_N_IN) && !READ_OUT)
    else $error("byte lane mask wrong");

  // Global write writes every lane whatever the other controls say.
  a_global_all: assert property (
    active_now && !GLOBAL_WRITE_N_IN
    |=> BYTE_WRITE_OUT == sram_input_pkg::LANES_ALL)
    else $error("global write did not write all bytes");

  // No lane is written while both write controls stay high.
  a_qual_needed: assert property (
    GLOBAL_WRITE_N_IN && BYTE_WRITE_QUALIFIER_N_IN
    |=> BYTE_WRITE_OUT == sram_input_pkg::LANES_NONE)
    else $error("byte write without qualifier");

  // An advance edge of a live burst steps the counter by one.
  a_burst_step: assert property (
    !load_now && SELECTED_OUT && !BURST_ADVANCE_N_IN
    |=> BURST_SEED_BITS_OUT
        == $past(BURST_SEED_BITS_OUT) + sram_input_pkg::BURST_STEP)
    else $error("burst counter did not advance");

  // Without load or advance the counter holds.
  a_burst_hold: assert property (
    !load_now && BURST_ADVANCE_N_IN |=> $stable(BURST_SEED_BITS_OUT))
    else $error("burst counter moved without cause");

  // A load leaves the selection equal to all selects active.
  a_select_all: assert property (
    load_now |=> SELECTED_OUT == $past(sel_now))
    else $error("selection does not follow the chip selects");

  // A processor strobe with the primary select high changes nothing.
  a_proc_ignored: assert property (
    !PROCESSOR_ADDRESS_STROBE_N_IN && PRIMARY_CHIP_SELECT_N_IN
    |=> $stable(ADDRESS_OUT) && $stable(SELECTED_OUT) && !ADDRESS_LOAD_OUT)
    else $error("processor strobe acted while primary select high");

  // After two load-free edges in a row the selection holds across the second.
  a_select_held: assert property (
    !load_now ##1 !load_now |=> $stable(SELECTED_OUT))
    else $error("selection changed without an address load");

  // Both strobes low behave as the processor strobe alone.
  a_proc_priority: assert property (
    !PROCESSOR_ADDRESS_STROBE_N_IN && !CONTROLLER_ADDRESS_STROBE_N_IN
    && !PRIMARY_CHIP_SELECT_N_IN && sel_now
    |=> ADDRESS_LOAD_OUT && ADDRESS_OUT == $past(ADDRESS_IN))
    else $error("processor strobe not honoured over controller strobe");

  // A selected load with both write controls high reads.
  a_load_read: assert property (
    load_now && sel_now && GLOBAL_WRITE_N_IN && BYTE_WRITE_QUALIFIER_N_IN
    |=> READ_OUT && BYTE_WRITE_OUT == sram_input_pkg::LANES_NONE)
    else $error("selected load with no write was not a read");

  // Main scenarios worth seeing.
  c_proc_load: cover property (proc_take && sel_now);
  c_ctrl_load: cover property (ctrl_take && sel_now);
  c_full_burst: cover property (
    load_now && sel_now ##1 (!load_now && !BURST_ADVANCE_N_IN) [*3]);
  c_byte_write: cover property (
    active_now && GLOBAL_WRITE_N_IN && !BYTE_WRITE_QUALIFIER_N_IN);
  c_deselect: cover property (SELECTED_OUT && load_now && !sel_now);

endmodule : sram_input_ctrl

/* File: tb/sram_host_model.sv */
`timescale 1ns/1ps

// ---------------------------------------------------------------------------
// Bus controller model: each call holds one request for exactly one edge.
// ---------------------------------------------------------------------------
module sram_host_model #(
  parameter int ADDR_W = 18
) (
  // Clock shared with the SRAM.
  input  wire logic              clk_in,
  // Address and burst controls.
  output logic      [ADDR_W-1:0] address_out,
  output logic                   processor_address_strobe_n_out,
  output logic                   controller_address_strobe_n_out,
  output logic                   burst_advance_n_out,
  // Chip selects, only meaningful on load edges.
  output logic                   primary_chip_select_n_out,
  output logic                   secondary_chip_select_out,
  output logic                   third_chip_select_n_out,
  // Write controls.
  output logic                   global_write_n_out,
  output logic                   byte_write_qualifier_n_out,
  output logic      [3:0]        byte_lane_write_select_n_out
);
  // Start idle and deselected so reset sees no request.
  initial begin
    address_out = '0;
    {processor_address_strobe_n_out, controller_address_strobe_n_out,
     burst_advance_n_out, primary_chip_select_n_out,
     secondary_chip_select_out, third_chip_select_n_out,
     global_write_n_out, byte_write_qualifier_n_out} = 8'hff;
    byte_lane_write_select_n_out = 4'hf;
  end

  // Control code order: strobes, advance, three selects, global, qualifier.
  // The caller sets the qualifier low for every selective byte write.
  task automatic send(input logic [ADDR_W-1:0] a, input logic [7:0] c,
                      input logic [3:0] lanes_n);
    @(posedge clk_in);
    address_out <= a;
    {processor_address_strobe_n_out, controller_address_strobe_n_out,
     burst_advance_n_out, primary_chip_select_n_out,
     secondary_chip_select_out, third_chip_select_n_out,
     global_write_n_out, byte_write_qualifier_n_out} <= c;
    byte_lane_write_select_n_out <= lanes_n;
    @(posedge clk_in);
    // Released address and lane lines show the inverse, so a stale value can never match.
    address_out <= ~a;
    byte_lane_write_select_n_out <= ~lanes_n;
    processor_address_strobe_n_out <= 1'b1;
    controller_address_strobe_n_out <= 1'b1;
    burst_advance_n_out <= 1'b1;
    global_write_n_out <= 1'b1;
    byte_write_qualifier_n_out <= 1'b1;
  endtask : send
endmodule : sram_host_model

/* File: tb/sync_sram_input_control_bench.sv */
`timescale 1ns/1ps

// ---------------------------------------------------------------------------
// Self-checking bench for the SRAM input qualifier.
// ---------------------------------------------------------------------------
module sync_sram_input_control_bench;
  localparam int AW = 18;             // Address width under test.
  logic          clk;                 // Bench clock.
  logic          rst;                 // Asynchronous reset.
  logic [AW-1:0] address, cap_addr;   // Bus address and captured copy.
  logic          ps_n, cs_n, adv_n;   // Strobes and advance.
  logic          sel1_n, sel2, sel3_n; // Chip selects.
  logic          gw_n, bwe_n, sel, load, rd; // Write controls and status.
  logic [3:0]    lanes_n, bw;         // Lane selects and written lanes.
  logic [1:0]    burst;               // Burst position.
  logic [AW-1:0] cap_addr_b;          // Captured address, two-select copy.
  logic          sel_b;               // Selection, two-select copy.
  int            num_errors = 0;      // Mismatches.
  int            n_tests = 0;         // Comparisons.

  sram_host_model #(.ADDR_W(AW)) i_sram_host_model (
    .clk_in(clk), .address_out(address),
    .processor_address_strobe_n_out(ps_n),
    .controller_address_strobe_n_out(cs_n),
    .burst_advance_n_out(adv_n), .primary_chip_select_n_out(sel1_n),
    .secondary_chip_select_out(sel2), .third_chip_select_n_out(sel3_n),
    .global_write_n_out(gw_n), .byte_write_qualifier_n_out(bwe_n),
    .byte_lane_write_select_n_out(lanes_n));

  sram_input_ctrl #(.ADDR_W(AW), .HAS_THIRD_CS(1'b1)) i_sram_input_ctrl (
    .CLK_IN(clk), .SYS_RST_IN(rst), .ADDRESS_IN(address),
    .PROCESSOR_ADDRESS_STROBE_N_IN(ps_n),
    .CONTROLLER_ADDRESS_STROBE_N_IN(cs_n), .BURST_ADVANCE_N_IN(adv_n),
    .PRIMARY_CHIP_SELECT_N_IN(sel1_n), .SECONDARY_CHIP_SELECT_IN(sel2),
    .THIRD_CHIP_SELECT_N_IN(sel3_n), .GLOBAL_WRITE_N_IN(gw_n),
    .BYTE_WRITE_QUALIFIER_N_IN(bwe_n),
    .BYTE_LANE_WRITE_SELECT_N_IN(lanes_n), .ADDRESS_OUT(cap_addr),
    .BURST_SEED_BITS_OUT(burst), .SELECTED_OUT(sel),
    .ADDRESS_LOAD_OUT(load), .READ_OUT(rd), .BYTE_WRITE_OUT(bw));

  // Same bus into a build without the third select, which must ignore it.
  sram_input_ctrl #(.ADDR_W(AW), .HAS_THIRD_CS(1'b0)) i_sram_input_ctrl_2cs (
    .CLK_IN(clk), .SYS_RST_IN(rst), .ADDRESS_IN(address),
    .PROCESSOR_ADDRESS_STROBE_N_IN(ps_n),
    .CONTROLLER_ADDRESS_STROBE_N_IN(cs_n), .BURST_ADVANCE_N_IN(adv_n),
    .PRIMARY_CHIP_SELECT_N_IN(sel1_n), .SECONDARY_CHIP_SELECT_IN(sel2),
    .THIRD_CHIP_SELECT_N_IN(sel3_n), .GLOBAL_WRITE_N_IN(gw_n),
    .BYTE_WRITE_QUALIFIER_N_IN(bwe_n),
    .BYTE_LANE_WRITE_SELECT_N_IN(lanes_n), .ADDRESS_OUT(cap_addr_b),
    .BURST_SEED_BITS_OUT(), .SELECTED_OUT(sel_b),
    .ADDRESS_LOAD_OUT(), .READ_OUT(), .BYTE_WRITE_OUT());

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Four-state compare, so an unknown never counts as a match.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One request, then a look at every output one edge later.
  task automatic step(input logic [AW-1:0] a, input logic [7:0] c,
                      input logic [3:0] ln, input logic [AW-1:0] ea,
                      input logic [1:0] eb, input logic [3:0] esl,
                      input logic [3:0] ew);
    i_sram_host_model.send(a, c, ln);
    #1;
    check(cap_addr, ea);
    check(burst, eb);
    check({sel, load, rd}, esl[2:0]);
    check(bw, ew);
  endtask : step

  // Verdict in one place, for the main sequence and the watchdog alike.
  task automatic wrap_up();
    $display("Counts: %0d checks, %0d mismatches", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  // Load, then byte, global and plain advances, wrapping the counter.
  task automatic t_burst();
    step(18'h2a5b6, 8'h6b, 4'hf, 18'h2a5b6, 2'h2, 4'h7, 4'h0);
    step(18'h00000, 8'hca, 4'he, 18'h2a5b6, 2'h3, 4'h4, 4'h1);
    step(18'h00000, 8'hc8, 4'hf, 18'h2a5b6, 2'h0, 4'h4, 4'hf);
    step(18'h00000, 8'hcb, 4'h0, 18'h2a5b6, 2'h1, 4'h5, 4'h0);
    $display("Test burst done");
  endtask : t_burst

  // Each select inactive in turn deselects and keeps the old address.
  task automatic t_deselect();
    logic [7:0]    codes [3] = '{8'hbb, 8'ha3, 8'haf};
    logic [AW-1:0] a_ld;   // Address loaded in this round.
    logic [AW-1:0] a_far;  // Address offered on the deselecting load.
    logic [1:0]    b_ld;   // Seed bits of the loaded address.
    for (int i = 0; i < 3; i++) begin
      a_ld  = AW'(18'h10000 + i);
      a_far = AW'(18'h3fffc - i);
      b_ld  = 2'(i);
      step(a_ld, 8'hab, 4'hf, a_ld, b_ld, 4'h7, 4'h0);
      step(a_far, codes[i], 4'hf, a_ld, b_ld, 4'h0, 4'h0);
    end
    // The build without the third select took the last load as selected.
    check({sel_b, cap_addr_b}, {1'b1, 18'h3fffa});
    step(18'h00000, 8'hcb, 4'hf, 18'h10002, 2'h2, 4'h0, 4'h0);
    $display("Test deselect done");
  endtask : t_deselect

  // Processor strobe under a high primary select, and both strobes low.
  task automatic t_strobes();
    step(18'h00ab1, 8'hab, 4'hf, 18'h00ab1, 2'h1, 4'h7, 4'h0);
    i_sram_host_model.send(18'h12346, 8'h7b, 4'hf);
    #1;
    check({cap_addr, burst, load}, {18'h00ab1, 2'h1, 1'b0});
    step(18'h0fff3, 8'h2b, 4'hf, 18'h0fff3, 2'h3, 4'h7, 4'h0);
    i_sram_host_model.send(18'h00004, 8'h3b, 4'hf);
    #1;
    check({cap_addr, load}, {18'h0fff3, 1'b0});
    $display("Test strobes done");
  endtask : t_strobes

  // A burst edge with a select dropped keeps the earlier selection.
  task automatic t_hold();
    step(18'h22220, 8'hab, 4'hf, 18'h22220, 2'h0, 4'h7, 4'h0);
    step(18'h00000, 8'hc3, 4'hf, 18'h22220, 2'h1, 4'h5, 4'h0);
    $display("Test hold done");
  endtask : t_hold

  // Reset for four cycles, then the scenarios in order.
  initial begin
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1;
    check({sel, load, rd, bw}, 7'h00);
    t_burst();
    t_deselect();
    t_strobes();
    t_hold();
    wrap_up();
  end

  // Watchdog: the tests need well under 200 cycles.
  initial begin
    repeat (2000) @(posedge clk);
    num_errors++;
    $display("BAD at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule : sync_sram_input_control_bench
